// File: msr_slave.sv
// memory slave: address decode, refresh arbitration, read/write reply
`timescale 1ns/1ps
`include "msr_defs.svh"
module msr_slave
   import msr_pkg::*;
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   // jumpered range
   input  wire logic [`MSR_ADDR_W-1:0]    range_base,
   input  wire logic [`MSR_ADDR_W-1:0]    range_size,
   // bus strobes, active high after receivers
   input  wire logic                      sync_strobe,
   input  wire logic                      io_page_strobe,
   input  wire logic                      write_byte_strobe,
   input  wire logic                      data_input_strobe,
   input  wire logic                      data_output_strobe,
   // multiplexed address/data lines, three signals
   input  wire logic [`MSR_ADDR_W-1:0]    muxed_addr_data_lines_in,
   output logic      [`MSR_ADDR_W-1:0]    muxed_addr_data_lines_out,
   output logic                           muxed_addr_data_lines_oe,
   // reply
   output logic                           bus_reply,
   // refresh arbitration
   input  wire logic                      refresh_request,
   input  wire logic                      refresh_busy,
   // row and column bits for the array drivers
   output logic      [`MSR_ROW_W-1:0]     row_addr,
   output logic      [`MSR_COL_W-1:0]     col_addr,
   output logic                           memory_select
);
   // ==================================================================
   // pin synchronisers: three stages, a change counts when 2 and 3 agree
   // ==================================================================
   localparam int NS = 5;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] s1;
   logic [NS-1:0] s2;
   logic [NS-1:0] s3;
   logic [NS-1:0] pin_q;
   assign pin_raw = {sync_strobe, io_page_strobe, write_byte_strobe,
                     data_input_strobe, data_output_strobe};

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
         // first stage is read only by the second
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               s1[gi]    <= 1'b0;
               s2[gi]    <= 1'b0;
               s3[gi]    <= 1'b0;
               pin_q[gi] <= 1'b0;
            end else begin
               s1[gi] <= pin_raw[gi];
               s2[gi] <= s1[gi];
               s3[gi] <= s2[gi];
               if (s2[gi] == s3[gi]) begin
                  pin_q[gi] <= s3[gi];
               end
            end
         end
      end
   endgenerate

   wire sync_q = pin_q[4];
   wire bs7_q  = pin_q[3];
   wire wtbt_q = pin_q[2];
   wire din_q  = pin_q[1];
   wire dout_q = pin_q[0];

   // ==================================================================
   // address decode
   // ==================================================================
   logic                     sync_d;
   logic [`MSR_ADDR_W-1:0]   addr_lat;
   logic                     sel;
   logic                     read_req;
   logic                     write_req;
   logic                     write_byte;
   logic                     wr_done;
   msr_state_e               state;
   msr_state_e               next_state;
   logic [`MSR_CNT_W-1:0]    cnt;
   logic                     timing_reply_internal;
   logic [`MSR_DATA_W-1:0]   rd_lat;
   logic                     perr_lat;
   logic [`MSR_WORD_W-1:0]   mem_rdata;

   // bus lines are quiet here because the master held them through sync
   wire [`MSR_ADDR_W-1:0] bus_addr = muxed_addr_data_lines_in;
   wire [`MSR_ADDR_W-1:0] addr_off = bus_addr - range_base;
   wire in_range   = (bus_addr >= range_base) && (addr_off < range_size);  // R1
   wire io_page_select_internal = bs7_q;
   wire accept     = in_range && !io_page_select_internal;                 // R2 R16
   wire sync_rise  = sync_q && !sync_d;
   wire refresh_idle = !refresh_request && !refresh_busy;                  // R5
   wire any_req    = read_req || write_req;
   wire acc_end    = (cnt == `MSR_CNT_W'(`MSR_ACCESS_CYC - 1));
   // a write may follow a finished read inside the same cycle (rmw)
   wire wr_slot    = (state == MSR_IDLE) || (state == MSR_DONE);

   // ==================================================================
   // address latch and request flags
   // ==================================================================
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_d   <= 1'b0;
         addr_lat <= '0;
         sel      <= 1'b0;
      end else begin
         sync_d <= sync_q;
         if (sync_rise) begin
            addr_lat <= bus_addr;  // R4
            sel      <= accept;    // R1 R16
         end else if (!sync_q) begin
            sel <= 1'b0;
         end
      end
   end

   // read flag only when write/byte strobe negated at sync (plain read or rmw)
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         read_req  <= 1'b0;
         write_req <= 1'b0;
         write_byte <= 1'b0;
      end else begin
         if (sync_rise && accept && !wtbt_q) begin
            read_req <= 1'b1;  // R3 R4 R12
         end else if (state == MSR_ARB && refresh_idle && read_req) begin
            read_req <= 1'b0;
         end else if (!sync_q) begin
            read_req <= 1'b0;
         end
         if (sel && dout_q && !wr_done && !write_req && wr_slot) begin
            write_req  <= 1'b1;    // R15
            write_byte <= wtbt_q;  // R13
         end else if (state == MSR_ACC && acc_end) begin
            // held through the access so the array write still sees it
            write_req <= 1'b0;
         end else if (!sync_q) begin
            write_req <= 1'b0;
         end
      end
   end

   // ==================================================================
   // memory timing state machine
   // ==================================================================
   always_comb begin
      next_state = state;
      unique case (state)
         MSR_IDLE: if (any_req) next_state = MSR_ARB;
         MSR_ARB:  if (refresh_idle) next_state = MSR_ACC;  // R5 R12
         MSR_ACC:  if (acc_end) next_state = MSR_DONE;
         MSR_DONE: if (!sync_q) next_state = MSR_IDLE;
                   else if (write_req) next_state = MSR_ARB;
      endcase
   end

   // timing reply held until the sync strobe ends the cycle or a pending write sends done back to arbitration
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= MSR_IDLE;
         cnt   <= '0;
         timing_reply_internal <= 1'b0;
         wr_done <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= (state == MSR_ACC) ? cnt + 1'b1 : '0;
         if (state == MSR_ACC && acc_end) begin
            timing_reply_internal <= 1'b1;
         end else if (!sync_q || (state == MSR_DONE && write_req)) begin
            timing_reply_internal <= 1'b0;
         end
         if (state == MSR_ACC && acc_end && write_req) begin
            wr_done <= 1'b1;
         end else if (!sync_q) begin
            wr_done <= 1'b0;
         end
      end
   end

   // ==================================================================
   // array, parity and read data latch
   // ==================================================================
   wire [`MSR_DATA_W-1:0] wdat = bus_addr[`MSR_DATA_W-1:0];
   wire [`MSR_WORD_W-1:0] wword = {^wdat[15:8], ^wdat[7:0], wdat};  // R14
   wire mem_we = (state == MSR_ACC) && acc_end && write_req;
   wire [1:0] mem_be = write_byte ? (addr_lat[0] ? 2'b10 : 2'b01) : 2'b11;  // R13
   wire rd_perr = (^mem_rdata[15:8] != mem_rdata[17]) ||
                  (^mem_rdata[7:0] != mem_rdata[16]);

   msr_mem u_mem (
      .clk     (clk),
      .we      (mem_we),
      .byte_en (mem_be),
      .addr    (addr_lat[`MSR_MEM_AW:1]),
      .wdata   (wword),
      .rdata   (mem_rdata)
   );

   // latch the checked word as the access ends
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_lat   <= '0;
         perr_lat <= 1'b0;
      end else if (state == MSR_ACC && acc_end && !write_req) begin
         rd_lat   <= mem_rdata[`MSR_DATA_W-1:0];  // R9
         perr_lat <= rd_perr;                     // R9
      end
   end

   // ==================================================================
   // reply and drivers
   // ==================================================================
   wire rd_reply = sel && din_q && timing_reply_internal;                 // R7 R8 R10
   wire wr_reply = sel && dout_q && wr_done && timing_reply_internal;     // R15
   assign bus_reply = rd_reply || wr_reply;
   assign muxed_addr_data_lines_oe = rd_reply;                             // R7 R10
   assign muxed_addr_data_lines_out = {4'h0, {2{perr_lat}}, rd_lat};       // R9
   assign memory_select = sel;
   assign row_addr = addr_lat[`MSR_ROW_LO +: `MSR_ROW_W];                  // R4
   assign col_addr = addr_lat[`MSR_COL_LO +: `MSR_COL_W];                  // R4
endmodule

// File: msr_defs.svh
// constants for the memory slave read dialogue block
// =====================================================================
// What this block does
// [R1] capture 22-bit address, compare with jumpered range, select only accepted addresses
// [R2] memory select only while io page strobe negated; master keeps it negated
// [R3] write/byte strobe negated in address phase means prepare a read request
// [R4] on sync strobe latch address, row and column bits, set read request
// [R5] read request arbitrated against refresh; timing starts only when refresh idle
// [R6] master holds sync strobe asserted through the whole data phase
// [R7] data drivers enabled after data input strobe only once timing reply active
// [R8] bus reply asserted when data input strobe and timing reply both active
// [R9] read data parity checked, latched, driven; bits 16 and 17 show parity error
// [R10] data input strobe negated: negate reply and stop driving read data
// [R11] master takes data, negates data input, then sync after reply drops
// [R12] read-modify-write address phase behaves as read with refresh arbitration
// [R13] read-modify-write write part: byte when write/byte strobe asserted, else word
// [R14] writes generate two parity bits; word writes store all 18 bits, byte writes one byte and its parity bit
// [R15] data output strobe raises write request; reply after write, drop with strobe
// [R16] rejected address or io page strobe: no timing, no data, no reply
// =====================================================================
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH
`define MSR_ADDR_W     22
`define MSR_DATA_W     16
`define MSR_WORD_W     18
`define MSR_MEM_AW     10
`define MSR_ROW_LO     1
`define MSR_ROW_W      5
`define MSR_COL_LO     6
`define MSR_COL_W      5
`define MSR_PERR_LO    16
// access time of the array, in ns, and its cycle count at 50 MHz
`define MSR_ACCESS_NS  100
`define MSR_CLK_NS     20
`define MSR_ACCESS_CYC ((`MSR_ACCESS_NS + `MSR_CLK_NS - 1) / `MSR_CLK_NS)
`define MSR_CNT_W      4
`define MSR_BASE_DEF   22'h000000
`define MSR_SIZE_DEF   22'h000800
`endif

// File: msr_pkg.sv
// types for the memory slave read dialogue block
package msr_pkg;
   // gray codes along idle -> wait_arb -> access -> done
   typedef enum logic [1:0] {
      MSR_IDLE  = 2'b00,
      MSR_ARB   = 2'b01,
      MSR_ACC   = 2'b11,
      MSR_DONE  = 2'b10
   } msr_state_e;
endpackage

// File: msr_mem.sv
// small synchronous array with byte writes and registered read data
`timescale 1ns/1ps
`include "msr_defs.svh"
module msr_mem
   import msr_pkg::*;
(
   // clock
   input  wire logic                      clk,
   // write side
   input  wire logic                      we,
   input  wire logic [1:0]                byte_en,
   input  wire logic [`MSR_MEM_AW-1:0]    addr,
   input  wire logic [`MSR_WORD_W-1:0]    wdata,
   // read side
   output logic      [`MSR_WORD_W-1:0]    rdata
);
   logic [`MSR_WORD_W-1:0] cells [0:(1<<`MSR_MEM_AW)-1];

   // low byte plus its parity bit, high byte plus its parity bit
   always_ff @(posedge clk) begin
      if (we && byte_en[0]) begin
         cells[addr][7:0] <= wdata[7:0];
         cells[addr][16]  <= wdata[16];
      end
      if (we && byte_en[1]) begin
         cells[addr][15:8] <= wdata[15:8];
         cells[addr][17]   <= wdata[17];
      end
      rdata <= cells[addr];
   end
endmodule

// File: msr_slave_chk.sv
// checker for the memory slave reply and drive rules
`timescale 1ns/1ps
`include "msr_defs.svh"
module msr_slave_chk (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   sys_rst,
   // strobes and refresh
   input wire logic                   data_input_strobe,
   input wire logic                   data_output_strobe,
   input wire logic                   refresh_request,
   input wire logic                   refresh_busy,
   // design outputs
   input wire logic [`MSR_ADDR_W-1:0] muxed_addr_data_lines_out,
   input wire logic                   muxed_addr_data_lines_oe,
   input wire logic                   bus_reply,
   input wire logic [`MSR_ROW_W-1:0]  row_addr,
   input wire logic [`MSR_COL_W-1:0]  col_addr,
   input wire logic                   memory_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // steps of a transfer: reply rising, read strobe withdrawn
   sequence s_up; $rose(bus_reply); endsequence
   sequence s_gone; $fell(data_input_strobe) && !data_output_strobe; endsequence
   property p_oe; muxed_addr_data_lines_oe |-> bus_reply; endproperty
   property p_cause; s_up |-> $past(data_input_strobe || data_output_strobe, 2); endproperty
   property p_par; bus_reply && muxed_addr_data_lines_oe |->
      muxed_addr_data_lines_out[21:18] == 4'h0 &&
      muxed_addr_data_lines_out[17] == muxed_addr_data_lines_out[16]; endproperty
   property p_drop; s_gone |-> ##[1:8] !bus_reply; endproperty
   // margin of one cycle under the walk, the arbiter looks at refresh first
   property p_ref; s_up |-> $past(!refresh_busy && !refresh_request, 5); endproperty
   property p_wr; s_up and data_output_strobe |-> !muxed_addr_data_lines_oe; endproperty
   property p_sel; bus_reply |-> memory_select; endproperty
   property p_rc; bus_reply && $past(bus_reply) |-> $stable({row_addr, col_addr}); endproperty
   a_oe: assert property (p_oe) else $error("drive without reply");
   a_cause: assert property (p_cause) else $error("reply without strobe");
   a_par: assert property (p_par) else $error("upper lines wrong");
   a_drop: assert property (p_drop) else $error("reply held");
   a_ref: assert property (p_ref) else $error("access during refresh");
   a_wr: assert property (p_wr) else $error("drive on write");
   a_sel: assert property (p_sel) else $error("reply unselected");
   a_rc: assert property (p_rc) else $error("row or column moved");
endmodule
bind msr_slave msr_slave_chk chk_u (.clk, .sys_rst, .data_input_strobe, .data_output_strobe,
   .refresh_request, .refresh_busy, .muxed_addr_data_lines_out, .muxed_addr_data_lines_oe,
   .bus_reply, .row_addr, .col_addr, .memory_select);

// File: msr_master.sv
// bus master model for the memory slave dialogues
`timescale 1ns/1ps
`include "msr_defs.svh"
module msr_master (
   // clock
   input wire logic                   clk,
   // strobes and lines toward the slave
   output logic                       sync_strobe,
   output logic                       io_page_strobe,
   output logic                       write_byte_strobe,
   output logic                       data_input_strobe,
   output logic                       data_output_strobe,
   output logic [`MSR_ADDR_W-1:0]     muxed_addr_data_lines_in,
   // answer
   input wire logic                   bus_reply
);
   time rtime;
   int  n;
   // idle bus at time zero
   initial begin
      {sync_strobe, io_page_strobe, write_byte_strobe} = 3'h0;
      {data_input_strobe, data_output_strobe} = 2'h0;
      muxed_addr_data_lines_in = 22'h000000;
   end
   // mode 0 read, 1 word write, 2 byte write, 3 read-modify-write word;
   // lines released show the inverse
   task automatic dialogue(input logic [21:0] a, input logic [1:0] mode, input logic bs7,
                           input logic [15:0] d, output logic got);
      logic wr;
      logic ok;
      wr = (mode == 2'h1) || (mode == 2'h2);
      ok = 1'b1;
      got = 1'b0;
      @(posedge clk);
      muxed_addr_data_lines_in <= a;
      io_page_strobe <= bs7;
      write_byte_strobe <= wr;
      repeat (6) @(posedge clk);
      sync_strobe <= 1'b1;
      repeat (6) @(posedge clk);
      io_page_strobe <= 1'b0;
      write_byte_strobe <= (mode == 2'h2);
      muxed_addr_data_lines_in <= wr ? {6'h00, d} : ~a;
      data_input_strobe <= !wr;
      data_output_strobe <= wr;
      for (n = 0; n < 60 && !got; n++) begin
         @(posedge clk);
         got = (bus_reply === 1'b1);
      end
      rtime = $time;
      data_input_strobe <= 1'b0;
      data_output_strobe <= 1'b0;
      muxed_addr_data_lines_in <= ~muxed_addr_data_lines_in;
      for (n = 0; n < 20 && bus_reply !== 1'b0; n++) @(posedge clk);
      // rmw: the write part starts one edge later, sync still held
      if (mode == 2'h3) begin
         ok = got;
         got = 1'b0;
         @(posedge clk);
         muxed_addr_data_lines_in <= {6'h00, d};
         data_output_strobe <= 1'b1;
         for (n = 0; n < 60 && !got; n++) begin
            @(posedge clk);
            got = (bus_reply === 1'b1);
         end
         got = got && ok;
         data_output_strobe <= 1'b0;
         for (n = 0; n < 20 && bus_reply !== 1'b0; n++) @(posedge clk);
      end
      sync_strobe <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule

// File: memory_slave_read_dialogue_tb.sv
// testbench for the memory slave read dialogue block
`timescale 1ns/1ps
`include "msr_defs.svh"
module memory_slave_read_dialogue_tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        refresh_request = 1'b0;
   logic        refresh_busy = 1'b0;
   logic [21:0] range_base = `MSR_BASE_DEF;
   logic [21:0] range_size = `MSR_SIZE_DEF;
   wire         sync_strobe, io_page_strobe, write_byte_strobe;
   wire         data_input_strobe, data_output_strobe;
   wire  [21:0] muxed_addr_data_lines_in, muxed_addr_data_lines_out;
   wire         muxed_addr_data_lines_oe, bus_reply, memory_select;
   wire  [4:0]  row_addr, col_addr;
   logic [21:0] notes[$];
   logic [15:0] seed = 16'h000A;
   logic        prev_reply, got;
   int          bad_count = 0, checks = 0, cyc = 0, i;
   time         rel;
   msr_slave dut_u (.clk, .sys_rst, .range_base, .range_size, .sync_strobe, .io_page_strobe,
      .write_byte_strobe, .data_input_strobe, .data_output_strobe, .muxed_addr_data_lines_in,
      .muxed_addr_data_lines_out, .muxed_addr_data_lines_oe, .bus_reply, .refresh_request,
      .refresh_busy, .row_addr, .col_addr, .memory_select);
   msr_master mst_u (.clk, .sync_strobe, .io_page_strobe, .write_byte_strobe,
      .data_input_strobe, .data_output_strobe, .muxed_addr_data_lines_in, .bus_reply);
   always #10 clk = ~clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // expected word noted first, then the master runs the read
   task automatic do_read(input logic [21:0] a, input logic bs7, input logic [15:0] d,
                          input logic g);
      if (g) notes.push_back({6'h00, d});
      mst_u.dialogue(a, 2'h0, bs7, 16'h0000, got);
      chk({21'h0, got}, {21'h0, g});
      chk({12'h000, col_addr, row_addr}, {12'h000, a[10:6], a[5:1]});
   endtask
   // a read reply compares the driven word with the oldest note; cycle ceiling
   always @(posedge clk) begin
      prev_reply <= bus_reply;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         close_out;
      end else if (bus_reply === 1'b1 && prev_reply === 1'b0 &&
                   muxed_addr_data_lines_oe === 1'b1) begin
         if (notes.size() == 0) chk(muxed_addr_data_lines_out, 22'h3FFFFF);
         else chk(muxed_addr_data_lines_out, notes.pop_front());
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      // word write, read back, then a byte into the odd half
      mst_u.dialogue(22'h000102, 2'h1, 1'b0, 16'hA55A, got);
      chk({21'h0, got}, 22'h000001);
      do_read(22'h000102, 1'b0, 16'hA55A, 1'b1);
      mst_u.dialogue(22'h000103, 2'h2, 1'b0, 16'h3C3C, got);
      chk({21'h0, got}, 22'h000001);
      do_read(22'h000102, 1'b0, 16'h3C5A, 1'b1);
      // read-modify-write: old word out first, new word in, then read back
      notes.push_back({6'h00, 16'h3C5A});
      mst_u.dialogue(22'h000102, 2'h3, 1'b0, 16'h5AA5, got);
      chk({21'h0, got}, 22'h000001);
      do_read(22'h000102, 1'b0, 16'h5AA5, 1'b1);
      // random words, the last one at the top of the range
      for (i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         mst_u.dialogue((i == 4) ? 22'h0007FE : {11'h000, seed[9:0], 1'b0}, 2'h1, 1'b0,
                        seed, got);
         do_read((i == 4) ? 22'h0007FE : {11'h000, seed[9:0], 1'b0}, 1'b0, seed, 1'b1);
      end
      // first address past the range, then the io page strobe
      do_read(22'h000800, 1'b0, 16'h0000, 1'b0);
      do_read(22'h000102, 1'b1, 16'h0000, 1'b0);
      // refresh running holds the read back until released
      refresh_busy <= 1'b1;
      refresh_request <= 1'b1;
      fork
         begin
            repeat (25) @(posedge clk);
            refresh_busy <= 1'b0;
            refresh_request <= 1'b0;
            rel = $time;
         end
         do_read(22'h000102, 1'b0, 16'h5AA5, 1'b1);
      join
      chk({21'h0, mst_u.rtime > rel + `MSR_ACCESS_NS}, 22'h000001);
      close_out;
   end
endmodule
